/* lxcfg_defines.svh */
// constants of the extended configuration decoder
`ifndef LXCFG_DEFINES_SVH
`define LXCFG_DEFINES_SVH

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define LXCFG_ADDR_CMD        4'h0
`define LXCFG_ADDR_CFG        4'h4
`define LXCFG_ADDR_MODE       4'h8

// ****************************************************************
// instruction codes and field positions
// ****************************************************************
`define LXCFG_SCREEN_CODE     7'h01
`define LXCFG_DISP_CODE       6'h01
`define LXCFG_ICON_CODE       5'h01
`define LXCFG_CMD_RS_BIT      8
`define LXCFG_CMD_RW_BIT      9
`define LXCFG_CMD_EXT_BIT     10
`define LXCFG_CFG_SPLIT_BIT   0
`define LXCFG_CFG_COLF_BIT    1
`define LXCFG_CFG_ROWF_BIT    2
`define LXCFG_CFG_ICONLY_BIT  3
`define LXCFG_CFG_BLINK_BIT   4
`define LXCFG_CFG_DIRECT_BIT  5
`define LXCFG_CFG_PHASE_BIT   6

// ****************************************************************
// geometry and timing
// ****************************************************************
`define LXCFG_COLS            7'h50
`define LXCFG_ROWS_TWO        5'h10
`define LXCFG_ROWS_ONE        5'h08
`define LXCFG_ICON_ROW_A      5'h11
`define LXCFG_ICON_ROW_B      5'h12
`define LXCFG_SPLIT_SUM       8'ha1
`define LXCFG_BLINK_DIV       16'hcc00
`define LXCFG_BLINK_HALF      16'h65ff
`define LXCFG_ODD_OFFSET      6'h20
`define LXCFG_CFG_RESET       6'h00

`endif

/* lxcfg_pkg.sv */
// types of the extended configuration decoder
package lxcfg_pkg;

    // ****************************************************************
    // persistent configuration
    // ****************************************************************
    typedef struct packed {
        logic direct_supply_bit;
        logic icon_blink_bit;
        logic icon_only_bit;
        logic row_flip;
        logic col_flip;
        logic split_mirror;
    } lxcfg_cfg_type;

    typedef enum logic [1:0] {
        LXCFG_MUX_18,
        LXCFG_MUX_9,
        LXCFG_MUX_2
    } lxcfg_mux_type;

    // ****************************************************************
    // scan position into the driver
    // ****************************************************************
    typedef struct packed {
        logic [6:0] col;
        logic [4:0] row;
    } lxcfg_scan_type;

    // ****************************************************************
    // mapped driver coordinates
    // ****************************************************************
    typedef struct packed {
        logic [6:0] col;
        logic [7:0] split_col;
        logic [4:0] row;
        logic       row_is_icon;
    } lxcfg_map_type;

endpackage

/* lxcfg_decoder.sv */
// extended configuration decoder with avalon-mm slave and scan mapping
// Notes on behaviour
// - decode extended instructions only when ext select=1, rs=0, rw=0.
// - split bit 0: column n pairs with column n+80.
// - split bit 1: column n pairs with column 161-n.
// - orientation instruction upper six bits 000001; flip 0 gives columns 1..80.
// - column flip 1 outputs columns from 80 down to 1.
// - row flip 0, two lines: rows 1..16, icons on rows 17 and 18.
// - row flip 0, single line: rows 1..8, icons on row 17.
// - row flip 1 reverses rows; icons 18 then 17, or 17 single line.
// - both flips together rotate the image by 180 degrees.
// - icon instruction upper bits 00001; icon-only 0 gives mux 1:18/1:9, char factor.
// - icon-only 1 drives icons only at mux 1:2, icon factor.
// - icon blink independent of cursor and character blink enable.
// - blink off: icon states from glyph ram characters 0 to 3.
// - blink on: two bits per icon, even/odd phases follow cursor blink.
// - odd phase reads characters 4 to 7, even phase characters 0 to 3.
// - blink off: characters 4 to 7 are ordinary user characters.
// - data bit 1 lights the icon, bit 0 blanks it.
// - direct bit 0: supply from internal generator or external voltage.
// - direct bit 1: generator off, display supply tied to generator input.
// - blink phases alternate at clock divided by 52224.
`timescale 1ns/10ps

`include "lxcfg_defines.svh"

module lxcfg_decoder (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic                  single_line_select,
    input  wire lxcfg_pkg::lxcfg_scan_type scan_pos,
    input  wire logic [4:0]            icon_group,
    input  wire logic [4:0]            glyph_ram_data,
    output lxcfg_pkg::lxcfg_map_type   drive_pos,
    output lxcfg_pkg::lxcfg_mux_type   mux_mode,
    output logic                       use_icon_factor,
    output logic                       generator_enable,
    output logic                       display_supply_output,
    output logic                       external_supply_allowed,
    output logic                       blink_odd_phase,
    output logic [5:0]                 glyph_ram_icon_addr,
    output logic                       glyph_ram_upper_free,
    output logic [4:0]                 icon_lit
);
    import lxcfg_pkg::*;

    // ****************************************************************
    // bus slave
    // ****************************************************************
    lxcfg_cfg_type cfg_q, cfg_d;
    logic          ack_q, ack_d;
    logic [31:0]   rdata_q, rdata_d;
    logic [10:0]   cmd;
    logic          cmd_ok;
    logic          blink_q, blink_d;
    logic [15:0]   div_q, div_d;

    // one wait state on every access: the answer is registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata    = rdata_q;
    assign cmd             = avs_writedata[10:0];
    assign cmd_ok          = avs_write & ~ack_q & avs_byteenable[0] & avs_byteenable[1]
                             & (avs_address == `LXCFG_ADDR_CMD)
                             & cmd[`LXCFG_CMD_EXT_BIT]
                             & ~cmd[`LXCFG_CMD_RS_BIT]
                             & ~cmd[`LXCFG_CMD_RW_BIT];

    // instruction decode and read mux
    always_comb begin
        cfg_d   = cfg_q; // held until the same instruction comes again
        ack_d   = (avs_read | avs_write) & ~ack_q;
        rdata_d = rdata_q;
        if (cmd_ok) begin
            if (cmd[7:1] == `LXCFG_SCREEN_CODE) begin
                cfg_d.split_mirror = cmd[0];
            end else if (cmd[7:2] == `LXCFG_DISP_CODE) begin
                cfg_d.col_flip = cmd[1];
                cfg_d.row_flip = cmd[0];
            end else if (cmd[7:3] == `LXCFG_ICON_CODE) begin
                cfg_d.icon_only_bit     = cmd[2];
                cfg_d.icon_blink_bit    = cmd[1];
                cfg_d.direct_supply_bit = cmd[0];
            end
        end
        if (avs_read & ~ack_q) begin
            unique case (avs_address)
                `LXCFG_ADDR_CFG: begin
                    rdata_d = {25'h0, blink_q, cfg_q};
                end
                `LXCFG_ADDR_MODE: begin
                    rdata_d = {28'h0000000, generator_enable, display_supply_output,
                               mux_mode};
                end
                default: begin
                    rdata_d = 32'h00000000; // unmapped and command word read zero
                end
            endcase
        end
    end

    // bus and configuration registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cfg_q   <= `LXCFG_CFG_RESET;
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            cfg_q   <= cfg_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // blink phase divider
    // ****************************************************************
    // own divider so icon blink never depends on character blink enable
    always_comb begin
        div_d   = div_q + 16'h0001;
        blink_d = blink_q;
        if (div_q == `LXCFG_BLINK_HALF) begin
            div_d   = 16'h0000;
            blink_d = ~blink_q; // two halves make one period of 52224
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_q   <= 16'h0000;
            blink_q <= 1'b0;
        end else begin
            div_q   <= div_d;
            blink_q <= blink_d;
        end
    end

    // ****************************************************************
    // icon fetch
    // ****************************************************************
    // odd phase only matters while blink is enabled
    assign blink_odd_phase      = cfg_q.icon_blink_bit & blink_q;
    assign glyph_ram_icon_addr  = {1'b0, icon_group}
                                  + (blink_odd_phase ? `LXCFG_ODD_OFFSET : 6'h00);
    assign glyph_ram_upper_free = ~cfg_q.icon_blink_bit;

    // ****************************************************************
    // mapped outputs, registered
    // ****************************************************************
    lxcfg_map_type map_q, map_d;
    logic [4:0]    lit_q, lit_d;
    logic [4:0]    nrows;

    always_comb begin
        nrows = single_line_select ? `LXCFG_ROWS_ONE : `LXCFG_ROWS_TWO;
        lit_d = glyph_ram_data; // a 1 lights, a 0 blanks
        map_d = '0;
        // column mirror, 1..80 or 80..1
        map_d.col = cfg_q.col_flip ? 7'(`LXCFG_COLS + 7'h01 - scan_pos.col)
                                   : scan_pos.col;
        // second half of the split screen
        map_d.split_col = cfg_q.split_mirror
                          ? 8'(`LXCFG_SPLIT_SUM - {1'b0, map_d.col})
                          : 8'({1'b0, map_d.col} + {1'b0, `LXCFG_COLS});
        // rows beyond the character rows are icon rows
        if (scan_pos.row > nrows) begin
            map_d.row_is_icon = 1'b1;
            if (single_line_select) begin
                map_d.row = `LXCFG_ICON_ROW_A;
            end else if (cfg_q.row_flip) begin
                map_d.row = (scan_pos.row == `LXCFG_ICON_ROW_A) ? `LXCFG_ICON_ROW_B
                                                                : `LXCFG_ICON_ROW_A;
            end else begin
                map_d.row = scan_pos.row;
            end
        end else begin
            map_d.row = cfg_q.row_flip ? 5'(nrows + 5'h01 - scan_pos.row)
                                       : scan_pos.row;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            map_q <= '0;
            lit_q <= 5'h00;
        end else begin
            map_q <= map_d;
            lit_q <= lit_d;
        end
    end

    assign drive_pos = map_q;
    assign icon_lit  = lit_q;

    // ****************************************************************
    // multiplex and supply control
    // ****************************************************************
    always_comb begin
        if (cfg_q.icon_only_bit) begin
            mux_mode = LXCFG_MUX_2;
        end else if (single_line_select) begin
            mux_mode = LXCFG_MUX_9;
        end else begin
            mux_mode = LXCFG_MUX_18;
        end
    end

    assign use_icon_factor         = cfg_q.icon_only_bit;
    assign generator_enable        = ~cfg_q.direct_supply_bit;
    assign display_supply_output   = cfg_q.direct_supply_bit; // tied to input
    assign external_supply_allowed = ~cfg_q.direct_supply_bit;

endmodule

/* lxcfg_checker.sv */
// assertion checker bound to the extended configuration decoder
`timescale 1ns/10ps
module lxcfg_checker (
    input wire logic                     clk_sys,
    input wire logic                     nrst,
    input wire logic                     single_line_select,
    input wire lxcfg_pkg::lxcfg_scan_type scan_pos,
    input wire logic [4:0]               icon_group,
    input wire logic [4:0]               glyph_ram_data,
    input wire lxcfg_pkg::lxcfg_map_type drive_pos,
    input wire lxcfg_pkg::lxcfg_mux_type mux_mode,
    input wire logic                     use_icon_factor,
    input wire logic                     generator_enable,
    input wire logic                     display_supply_output,
    input wire logic                     external_supply_allowed,
    input wire logic                     blink_odd_phase,
    input wire logic [5:0]               glyph_ram_icon_addr,
    input wire logic                     glyph_ram_upper_free,
    input wire logic [4:0]               icon_lit
);
    import lxcfg_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // length of an odd phase that the divider opened; zero when a write opened it
    logic [15:0] odd_len_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            odd_len_q <= 16'h0000;
        end else if ($rose(blink_odd_phase) && $stable(glyph_ram_upper_free)) begin
            odd_len_q <= 16'h0001;
        end else if (blink_odd_phase && odd_len_q != 16'h0000) begin
            odd_len_q <= odd_len_q + 16'h0001;
        end else begin
            odd_len_q <= 16'h0000;
        end
    end
    // odd phase entered by the divider; a config write would move upper_free too
    sequence s_odd_start;
        $rose(blink_odd_phase) && $stable(glyph_ram_upper_free);
    endsequence
    a_mux_pick: assert property (mux_mode == (use_icon_factor ? LXCFG_MUX_2 :
        single_line_select ? LXCFG_MUX_9 : LXCFG_MUX_18)) else $error("mux mode wrong");
    a_supply_mode: assert property (generator_enable == external_supply_allowed
        && display_supply_output == !generator_enable) else $error("supply mode wrong");
    a_icon_addr: assert property (glyph_ram_icon_addr == {1'b0, icon_group}
        + (blink_odd_phase ? 6'd32 : 6'd0)) else $error("icon address wrong");
    a_upper_busy: assert property (blink_odd_phase |-> !glyph_ram_upper_free)
        else $error("upper glyphs free in odd phase");
    a_icon_pass: assert property (nrst |=> icon_lit == $past(glyph_ram_data))
        else $error("icon state wrong");
    a_phase_hold: assert property (s_odd_start |=> blink_odd_phase[*8])
        else $error("odd phase too short");
    a_row_kind: assert property (nrst |=> drive_pos.row_is_icon ==
        ($past(scan_pos.row) > ($past(single_line_select) ? 5'd8 : 5'd16)))
        else $error("icon row flag wrong");
    a_icon_rows: assert property (drive_pos.row_is_icon |-> drive_pos.row inside {5'd17, 5'd18})
        else $error("icon row out of place");
    // half of the 52224 clock blink period, counted only for divider-made phases
    a_phase_len: assert property ($fell(blink_odd_phase) && $stable(glyph_ram_upper_free)
        && odd_len_q != 16'h0000 |-> odd_len_q == 16'h6600) else $error("odd phase length wrong");
endmodule

bind lxcfg_decoder lxcfg_checker u_lxcfg_checker (.clk_sys(clk_sys), .nrst(nrst),
    .single_line_select(single_line_select), .scan_pos(scan_pos), .icon_group(icon_group),
    .glyph_ram_data(glyph_ram_data), .drive_pos(drive_pos), .mux_mode(mux_mode),
    .use_icon_factor(use_icon_factor), .generator_enable(generator_enable),
    .display_supply_output(display_supply_output), .icon_lit(icon_lit),
    .external_supply_allowed(external_supply_allowed), .blink_odd_phase(blink_odd_phase),
    .glyph_ram_icon_addr(glyph_ram_icon_addr), .glyph_ram_upper_free(glyph_ram_upper_free));

/* lxcfg_host.sv */
// host model issuing instructions over avalon-mm
`timescale 1ns/10ps
module lxcfg_host (
    input  wire logic   clk_sys,
    input  wire logic   avs_waitrequest,
    output logic [3:0]  avs_address,
    output logic        avs_read,
    output logic        avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0]  avs_byteenable
);
    int n_to = 0;
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
    end
    // request held until waitrequest low; idle lines inverted so stale values never match
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64) n_to++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
        @(posedge clk_sys);
    endtask
endmodule

/* tb_top.sv */
// self-checking testbench of the extended configuration decoder
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import lxcfg_pkg::*;
    logic clk_sys = 0, nrst = 0, single_line_select = 0, chk = 0, chk_d = 0;
    logic [31:0] gl = 32'hba42, rnd = 32'hba42, got, exp, q[$];
    lxcfg_scan_type scan_pos = {7'd1, 5'd1};
    lxcfg_map_type  drive_pos;
    wire logic [3:0] avs_address, avs_byteenable;
    wire logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_read, avs_write, avs_waitrequest, blink_odd_phase;
    logic [4:0] icon_lit;
    int n_mismatch = 0, tests_run = 0, n;
    event ev_got;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial begin forever #25 clk_sys = ~clk_sys; end
    // random glyph data and group every cycle
    always @(posedge clk_sys) gl <= nx(gl);
    lxcfg_host u_lxcfg_host (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
    lxcfg_decoder u_lxcfg_decoder (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .single_line_select(single_line_select),
        .scan_pos(scan_pos), .icon_group(gl[9:5]), .glyph_ram_data(gl[4:0]),
        .drive_pos(drive_pos), .mux_mode(), .use_icon_factor(), .generator_enable(),
        .display_supply_output(), .external_supply_allowed(), .blink_odd_phase(blink_odd_phase),
        .glyph_ram_icon_addr(), .glyph_ram_upper_free(), .icon_lit(icon_lit));
    // scoreboard: oldest note against each result as it shows
    always @(posedge clk_sys) begin
        chk_d <= chk;
        if (avs_read && !avs_waitrequest) begin
            exp = q.pop_front();
            `CHK("readdata", exp, avs_readdata)
        end
        if (chk_d) begin
            exp = q.pop_front();
            `CHK("drive_pos", exp, {6'h0, icon_lit, drive_pos})
        end
    end
    always begin
        @(ev_got);
        exp = q.pop_front();
        `CHK("blink half period", exp, got)
    end
    task automatic go(input logic w, input logic [3:0] a, input logic [31:0] d);
        u_lxcfg_host.acc(w, a, d);
        if (u_lxcfg_host.n_to != 0) final_report;
    endtask
    task automatic wr(input logic [7:0] b); go(1'b1, 4'h0, {21'h0, 3'b100, b}); endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        q.push_back(e);
        go(1'b0, a, 32'h0);
    endtask
    // random scan point; expected mapping noted before it is driven
    task automatic scan(input logic l, input logic p, input logic f, input logic s);
        logic [6:0] c, c2;
        logic [4:0] r, r2;
        logic ic;
        logic [31:0] g;
        rnd = nx(rnd);
        g = nx(gl); // glyph word the decoder samples at the next edge
        c = 7'(1 + rnd[15:0] % 80);
        r = 5'(1 + rnd[31:16] % (s ? 9 : 18));
        if (s && r == 5'd9) r = 5'd17;
        ic = s ? (r > 5'd8) : (r > 5'd16);
        c2 = p ? 7'd81 - c : c;
        r2 = ic ? (s ? 5'd17 : (f ? 5'd35 - r : r)) : (f ? (s ? 5'd9 : 5'd17) - r : r);
        q.push_back({6'h0, g[4:0], c2, (l ? 8'd161 - c2 : c2 + 8'd80), r2, ic});
        scan_pos <= {c, r};
        chk <= 1'b1;
        @(posedge clk_sys);
        chk <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h8);
        rd(4'hc, 32'h0);
        go(1'b1, 4'h0, {21'h0, 3'b101, 8'h0f});
        go(1'b1, 4'h0, {21'h0, 3'b000, 8'h0f});
        go(1'b1, 4'h4, 32'h7f);
        rd(4'h4, 32'h0);
        $display("test reset and refusal done");
        for (int k = 0; k < 16; k++) begin
            wr({7'h01, k[0]});
            wr({6'h01, k[1], k[2]});
            single_line_select <= k[3];
            rd(4'h4, {29'h0, k[2:0]});
            repeat (2) scan(k[0], k[1], k[2], k[3]);
        end
        $display("test mapping done");
        for (int k = 0; k < 8; k++) begin
            wr({5'h01, k[2:0]});
            rd(4'h8, {28'h0, !k[0], k[0], k[2] ? 2'd2 : 2'd1});
        end
        $display("test icon control done");
        wr(8'h0a);
        n = 0;
        while (blink_odd_phase !== 1'b1 && n < 30000) begin @(posedge clk_sys); n++; end
        // a wait that runs out is a failure of its own
        if (n >= 30000) begin
            n_mismatch++;
            final_report;
        end
        n = 0;
        do begin @(posedge clk_sys); n++; end while (blink_odd_phase === 1'b1 && n < 30000);
        if (n >= 30000) begin
            n_mismatch++;
            final_report;
        end
        got = n;
        q.push_back(32'd26112);
        ->ev_got;
        rd(4'h4, 32'h17);
        $display("test blink done");
        final_report;
    end
    task automatic final_report;
        n_mismatch += u_lxcfg_host.n_to;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
endmodule
